// *** rtl/dram_seq_pkg.sv ***
// Constants, state codes and address helpers for the interleaved DRAM sequencer.
// Assumes a single 100 MHz system clock; all falling-edge events are retimed to it.
package dram_seq_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;  // System clock period
  localparam int RAS_PRE_MIN_NS = 20;  // Least row precharge time
  // Least row precharge in cycles, rounded up
  localparam logic [2:0] RAS_PRE_MIN_CYC =
    3'((RAS_PRE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] CAS_SHORT_CYC = 3'h2;  // Column pulse of 1.5 cycles
  localparam logic [2:0] CAS_LONG_CYC = 3'h3;  // Column pulse of 2.5 cycles
  localparam logic [2:0] CAS_BYPASS_CYC = 3'h1;  // Column pulse on a hinted write
  localparam logic [1:0] CAS_PULSE_SHORT = 2'h1;  // Pulse field code for 1.5 cycles

  // ----------------------------------------------------------------
  // Address layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32;  // Processor address width
  localparam int DRAM_MUX_ADDRESS_W = 12;  // Multiplexed DRAM address width
  localparam int COL_BASE = 9;  // Column bits for the smallest size code
  localparam int WORD_SHIFT = 3;  // Byte offset plus even/odd word bit
  localparam int PARITY_BIT = 2;  // Address bit that picks even or odd array

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,  // Waiting for an access
    ST_CSW = 3'h1,  // Select sampled; entered in fast and slow select alike
    ST_PRE = 3'h2,  // Rows negated for precharge
    ST_RAS = 3'h3,  // Rows asserted, row address out
    ST_RCD = 3'h4,  // Extra row-to-column delay
    ST_COL = 3'h5,  // Column address out
    ST_CAS = 3'h6  // Column strobes asserted
  } seq_state_t;

  // Column bits for a size code
  function automatic int col_bits(input logic [1:0] size);
    return COL_BASE + int'(size);
  endfunction

  // Page tag: address with the in-page bits cleared
  function automatic logic [ADDR_W-1:0] page_tag(input logic [ADDR_W-1:0] a,
                                                 input logic [1:0] size);
    logic [ADDR_W-1:0] m;
    m = (ADDR_W'(1) << (col_bits(size) + WORD_SHIFT)) - ADDR_W'(1);
    return a & ~m;
  endfunction

  // Bank-pair select: the first address bit above row and column
  function automatic logic bank_pair(input logic [ADDR_W-1:0] a, input logic [1:0] size);
    return a[2 * col_bits(size) + WORD_SHIFT];
  endfunction

endpackage

// *** rtl/pin_sync_if.sv ***
// Synchronised processor pins passed from the input stage to the sequencer.
// Assumes one clock domain on both sides.
`timescale 1ns/100ps
`default_nettype none
interface pin_sync_if;
  import dram_seq_pkg::*;
  logic ale;  // Address latch strobe, high active
  logic rd_n;  // Read strobe
  logic wr_n;  // Write strobe
  logic cs_n;  // Chip select
  logic near_n;  // Near-write hint
  logic [ADDR_W-1:0] addr;  // Access address
  logic [3:0] be_n;  // Byte lanes being written
  modport producer (output ale, rd_n, wr_n, cs_n, near_n, addr, be_n);
  modport consumer (input ale, rd_n, wr_n, cs_n, near_n, addr, be_n);
endinterface
`default_nettype wire

// *** rtl/pin_sync.sv ***
// Two-flop synchronisers for every processor pin.
// Assumes pins are asynchronous to the system clock; strobes idle high.
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ale_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic cs_n_i,
  input wire logic near_n_i,
  input wire logic [dram_seq_pkg::ADDR_W-1:0] addr_i,
  input wire logic [3:0] be_n_i,
  pin_sync_if.producer out
);
  import dram_seq_pkg::*;
  localparam int W = ADDR_W + 9;  // Width of the bundle
  localparam logic [W-1:0] IDLE_V = {1'b0, 4'hF, {ADDR_W{1'b0}}, 4'hF};  // Strobes high

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1_r;  // First stage, read only by the second
    logic [W-1:0] s2_r;  // Second stage
  } sync_st_t;
  sync_st_t st_r;
  sync_st_t st_nxt;

  // Shift the bundle one stage per clock
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1_r = {ale_i, rd_n_i, wr_n_i, cs_n_i, near_n_i, addr_i, be_n_i};
    st_nxt.s2_r = st_r.s1_r;
  end

  // Register the stages
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= {IDLE_V, IDLE_V};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign {out.ale, out.rd_n, out.wr_n, out.cs_n, out.near_n, out.addr, out.be_n} = st_r.s2_r;
endmodule
`default_nettype wire

// *** rtl/addr_mux.sv ***
// Row and column address selection for the multiplexed DRAM address.
// Assumes the sequencer's next-state address and its size code input; the sequencer registers the result.
`timescale 1ns/100ps
`default_nettype none
module addr_mux (
  input wire logic [dram_seq_pkg::ADDR_W-1:0] addr_i,
  input wire logic [1:0] size_i,
  input wire logic row_sel_i,
  output logic [dram_seq_pkg::DRAM_MUX_ADDRESS_W-1:0] mux_o
);
  import dram_seq_pkg::*;

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  // Column is the word index in the array; row sits just above it
  always_comb begin
    logic [ADDR_W-1:0] w;
    logic [ADDR_W-1:0] m;
    w = '0;
    m = (ADDR_W'(1) << col_bits(size_i)) - ADDR_W'(1);
    if (row_sel_i) begin
      w = (addr_i >> (col_bits(size_i) + WORD_SHIFT)) & m;
    end else begin
      w = (addr_i >> WORD_SHIFT) & m;
    end
    mux_o = w[DRAM_MUX_ADDRESS_W-1:0];
  end
endmodule
`default_nettype wire

// *** rtl/dram_seq.sv ***
// Sequencer for an interleaved DRAM of one or two bank-pairs.
// Assumes processor pins asynchronous to ref_clk_i and static configuration inputs.
`timescale 1ns/100ps
`default_nettype none
module dram_seq (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic ale_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic cs_n_i,
  input wire logic near_write_hint_n_i,
  input wire logic [dram_seq_pkg::ADDR_W-1:0] addr_i,
  input wire logic [3:0] byte_en_n_i,
  input wire logic [1:0] dram_size_i,
  input wire logic row_to_column_delay_bit_i,
  input wire logic slow_select_bit_i,
  input wire logic column_precharge_bit_i,
  input wire logic [1:0] cas_pulse_i,
  input wire logic near_hint_disable_bit_i,
  input wire logic [1:0] ras_precharge_i,
  output logic [3:0] ras_n_o,
  output logic [3:0] cas_n_o,
  output logic [dram_seq_pkg::DRAM_MUX_ADDRESS_W-1:0] dram_mux_address_o,
  output logic [3:0] bank_write_enables_n_o,
  output logic path_o,
  output logic ack_n_o,
  output logic ack_oe_o,
  output logic read_buffer_enable_n_o,
  output logic read_buffer_enable_oe_o,
  output logic page_open_o
);
  import dram_seq_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_r;  // Release shift register
  logic rst_n;  // Synchronised reset

  // Release reset two clocks after the pin goes high
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ----------------------------------------------------------------
  // Input stage and address mux
  // ----------------------------------------------------------------
  pin_sync_if pins ();  // Synchronised pins

  pin_sync u_sync (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .ale_i(ale_i),
    .rd_n_i(rd_n_i),
    .wr_n_i(wr_n_i),
    .cs_n_i(cs_n_i),
    .near_n_i(near_write_hint_n_i),
    .addr_i(addr_i),
    .be_n_i(byte_en_n_i),
    .out(pins.producer)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    seq_state_t st;  // Sequencer state
    logic [2:0] cnt;  // Cycles left in the state
    logic rows_open;  // A page is open
    logic [ADDR_W-1:0] open_tag;  // Tag of the open page
    logic open_pair;  // Bank-pair holding the open page
    logic [ADDR_W-1:0] addr;  // Latched access address
    logic is_wr;  // Access is a write
    logic [3:0] be_n;  // Latched byte lanes
    logic last_wr;  // Previous access was a write to our space
    logic hold;  // Access retired; wait for strobes to go high
    logic [3:0] ras_n;  // Row strobes
    logic [3:0] cas_n;  // Column strobes
    logic [3:0] bank_write_enables_n;  // Bank write enables
    logic row_sel;  // Mux shows the row address
    logic [DRAM_MUX_ADDRESS_W-1:0] dmux;  // Registered DRAM address
    logic path;  // Data path select
    logic ack_n;  // Acknowledge
    logic rdce_n;  // Read buffer enable
    logic oe;  // Acknowledge and buffer enable driven
  } seq_t;

  seq_t s_r;  // Registered state
  seq_t s_nxt;  // Next state
  logic [DRAM_MUX_ADDRESS_W-1:0] mux_w;  // Row or column address of the latched access

  addr_mux u_mux (
    .addr_i(s_nxt.addr),
    .size_i(dram_size_i),
    .row_sel_i(s_nxt.row_sel),
    .mux_o(mux_w)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic start_w;  // New access seen
  logic bypass_ok_w;  // Settings and history allow the near-write path
  logic hit_w;  // Latched access falls in the open page
  logic [2:0] pre_cyc_w;  // Row precharge cycles
  logic [2:0] cas_cyc_w;  // Column pulse cycles
  logic [3:0] pair_ras_w;  // Row strobes of the latched bank-pair

  // latch strobe with read or write strobe
  assign start_w = pins.ale && (!pins.rd_n || !pins.wr_n);
  // fast select, short precharge, short pulse, hint enabled, prior own write
  assign bypass_ok_w = !slow_select_bit_i && !column_precharge_bit_i &&
    (cas_pulse_i == CAS_PULSE_SHORT) && !near_hint_disable_bit_i && s_r.last_wr;
  // same-page test uses the size field
  assign hit_w = s_r.rows_open && (s_r.open_pair == bank_pair(s_r.addr, dram_size_i)) &&
    (page_tag(s_r.addr, dram_size_i) == s_r.open_tag);
  // programmed precharge, never below the least time
  assign pre_cyc_w = RAS_PRE_MIN_CYC + {1'b0, ras_precharge_i};
  // 1.5 or 2.5 cycle column pulse
  assign cas_cyc_w = (cas_pulse_i == CAS_PULSE_SHORT) ? CAS_SHORT_CYC : CAS_LONG_CYC;
  // strobes 0,1 serve bank-pair 0 and 2,3 bank-pair 1
  assign pair_ras_w = bank_pair(s_r.addr, dram_size_i) ? 4'hC : 4'h3;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Next-state logic for the whole access sequence
  always_comb begin
    s_nxt = s_r;
    s_nxt.dmux = mux_w;
    unique case (s_r.st)
      ST_IDLE: begin
        // Wait for strobes to clear after an access
        if (s_r.hold) begin
          s_nxt.hold = !(pins.rd_n && pins.wr_n);
        end else if (start_w) begin
          s_nxt.addr = pins.addr;
          s_nxt.is_wr = !pins.wr_n;
          s_nxt.be_n = pins.be_n;
          // address parity bit picks the array
          s_nxt.path = !pins.addr[PARITY_BIT];
          // hinted near write skips compare and select
          if (!pins.wr_n && bypass_ok_w && !pins.near_n && s_r.rows_open) begin
            s_nxt.row_sel = 1'b0;
            s_nxt.st = ST_CAS;
            s_nxt.cnt = CAS_BYPASS_CYC - 3'h1;
            s_nxt.oe = 1'b1;
            s_nxt.ack_n = 1'b0;
            s_nxt.bank_write_enables_n = pins.addr[PARITY_BIT] ? 4'h5 : 4'hA;
            s_nxt.cas_n = pins.be_n;
          end else if (slow_select_bit_i) begin
            s_nxt.st = ST_CSW;
          end else begin
            s_nxt.st = ST_CSW;
            s_nxt.cnt = 3'h1;
          end
        end
      end
      ST_CSW: begin
        // Select sampled now; cnt marks fast mode already waited
        if (pins.cs_n) begin
          // no DRAM controls outside our space
          s_nxt.st = ST_IDLE;
          s_nxt.hold = 1'b1;
          s_nxt.last_wr = 1'b0;
          s_nxt.cnt = 3'h0;
        end else begin
          s_nxt.oe = 1'b1;
          s_nxt.ack_n = 1'b1;
          s_nxt.rdce_n = 1'b1;
          s_nxt.cnt = 3'h0;
          // write enables once select is sampled, the cycle after the write strobe is seen
          if (s_r.is_wr) begin
            s_nxt.bank_write_enables_n = s_r.addr[PARITY_BIT] ? 4'h5 : 4'hA;
          end
          if (hit_w) begin
            s_nxt.row_sel = 1'b0;
            // compared hit write retires like a page read
            // slow select spends one more cycle on writes
            if (s_r.is_wr && slow_select_bit_i) begin
              s_nxt.st = ST_RCD;
            end else begin
              s_nxt.st = ST_COL;
            end
          end else if (s_r.rows_open) begin
            // row address out, rows negated for precharge
            s_nxt.row_sel = 1'b1;
            s_nxt.ras_n = 4'hF;
            s_nxt.st = ST_PRE;
            s_nxt.cnt = pre_cyc_w - 3'h1;
          end else begin
            // both halves of the pair for reads
            // both halves of the pair for writes
            s_nxt.row_sel = 1'b1;
            s_nxt.ras_n = ~pair_ras_w;
            s_nxt.st = ST_RAS;
          end
        end
      end
      ST_PRE: begin
        if (s_r.cnt == 3'h0) begin
          s_nxt.ras_n = ~pair_ras_w;
          s_nxt.st = ST_RAS;
        end else begin
          s_nxt.cnt = s_r.cnt - 3'h1;
        end
      end
      ST_RAS: begin
        s_nxt.rows_open = 1'b1;
        s_nxt.open_tag = page_tag(s_r.addr, dram_size_i);
        s_nxt.open_pair = bank_pair(s_r.addr, dram_size_i);
        // delay bit 0 goes straight to the column address
        // delay bit 1 spends one more cycle
        if (row_to_column_delay_bit_i) begin
          s_nxt.st = ST_RCD;
        end else begin
          s_nxt.row_sel = 1'b0;
          s_nxt.st = ST_COL;
        end
      end
      ST_RCD: begin
        s_nxt.row_sel = 1'b0;
        s_nxt.st = ST_COL;
      end
      ST_COL: begin
        // column strobes one cycle after the column address
        s_nxt.cas_n = s_r.is_wr ? s_r.be_n : 4'h0;
        s_nxt.st = ST_CAS;
        s_nxt.cnt = cas_cyc_w - 3'h1;
        // acknowledge in the last cycle of the pulse
        s_nxt.ack_n = (cas_cyc_w != 3'h1);
        s_nxt.rdce_n = s_r.is_wr || (cas_cyc_w != 3'h1);
      end
      ST_CAS: begin
        if (s_r.cnt == 3'h0) begin
          // rows stay asserted; column strobes released
          s_nxt.cas_n = 4'hF;
          s_nxt.bank_write_enables_n = 4'hF;
          s_nxt.ack_n = 1'b1;
          s_nxt.rdce_n = 1'b1;
          s_nxt.oe = 1'b0;
          s_nxt.last_wr = s_r.is_wr;
          s_nxt.hold = 1'b1;
          s_nxt.st = ST_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 3'h1;
          s_nxt.ack_n = (s_r.cnt != 3'h1);
          s_nxt.rdce_n = s_r.is_wr || (s_r.cnt != 3'h1);
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
  end

  // reset closes every page and negates all strobes
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{st: ST_IDLE, cnt: 3'h0, rows_open: 1'b0, open_tag: '0, open_pair: 1'b0,
               addr: '0, is_wr: 1'b0, be_n: 4'hF, last_wr: 1'b0, hold: 1'b0,
               ras_n: 4'hF, cas_n: 4'hF, bank_write_enables_n: 4'hF, row_sel: 1'b1, dmux: '0,
               path: 1'b1, ack_n: 1'b1, rdce_n: 1'b1, oe: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign ras_n_o = s_r.ras_n;
  assign cas_n_o = s_r.cas_n;
  assign dram_mux_address_o = s_r.dmux;
  assign bank_write_enables_n_o = s_r.bank_write_enables_n;
  assign path_o = s_r.path;
  assign ack_n_o = s_r.ack_n;
  assign ack_oe_o = s_r.oe;
  assign read_buffer_enable_n_o = s_r.rdce_n;
  assign read_buffer_enable_oe_o = s_r.oe;
  assign page_open_o = s_r.rows_open;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n);

  a_rows_after_read: assert property (
    (s_r.st == ST_CAS && s_r.cnt == 3'h0 && !s_r.is_wr) |=> (ras_n_o != 4'hF))
    else $error("rows dropped at end of read");
  a_precharge_len: assert property (
    $rose(ras_n_o == 4'hF && s_r.st == ST_PRE) |-> (ras_n_o == 4'hF) [*2])
    else $error("row precharge shorter than two cycles");
  a_bank_write_enables_one_pair: assert property (
    (bank_write_enables_n_o != 4'hF) |->
      (bank_write_enables_n_o == 4'h5 || bank_write_enables_n_o == 4'hA))
    else $error("both arrays write-enabled");
  a_bank_write_enables_read_off: assert property (
    (s_r.st == ST_CAS && !s_r.is_wr) |-> (bank_write_enables_n_o == 4'hF))
    else $error("write enable on a read");
  a_write_lanes: assert property (
    (s_r.st == ST_CAS && s_r.is_wr && cas_n_o != 4'hF) |-> (cas_n_o == s_r.be_n))
    else $error("column strobe on unwritten lane");
  a_path_parity: assert property (
    (s_r.st == ST_CAS) |-> (path_o == !s_r.addr[PARITY_BIT]))
    else $error("path select wrong for array");
  a_ack_with_oe: assert property (
    $fell(ack_n_o) |-> ack_oe_o ##1 $rose(ack_n_o) ##0 (cas_n_o == 4'hF))
    else $error("acknowledge not one cycle before column release");
  a_col_after_ras: assert property (
    (s_r.st == ST_RAS && !row_to_column_delay_bit_i) |=> (s_r.st == ST_COL) ##1
      (cas_n_o != 4'hF || s_r.is_wr))
    else $error("column strobes late after rows");
  a_no_ctrl_unsel: assert property (
    (s_r.st == ST_CSW && pins.cs_n) |=> (cas_n_o == 4'hF && !ack_oe_o) [*2])
    else $error("controls driven without select");
  a_reset_closed: assert property (
    $rose(rst_n) |-> (!page_open_o && ras_n_o == 4'hF && cas_n_o == 4'hF))
    else $error("page open after reset");

  c_page_miss: cover property (s_r.st == ST_PRE);
  c_page_hit_rd: cover property (s_r.st == ST_CSW && hit_w && !s_r.is_wr);
  c_near_write: cover property (s_r.st == ST_IDLE && s_nxt.st == ST_CAS);
  c_unselected: cover property (s_r.st == ST_CSW && pins.cs_n);
  c_slow_hit_wr: cover property (s_r.st == ST_CSW && hit_w && s_r.is_wr && slow_select_bit_i);
endmodule
`default_nettype wire

// *** tb/cpu_model.sv ***
// Processor bus model: drives strobes, address and hint, waits for acknowledge.
// Assumes acknowledge is an active-low pulse of one cycle.
`timescale 1ns/100ps
`default_nettype none
module cpu_model (
  input wire logic clk_i,
  input wire logic ack_n_i,
  output logic ale_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic cs_n_o,
  output logic near_n_o,
  output logic [31:0] addr_o,
  output logic [3:0] be_n_o
);
  logic [31:0] last_wa = 32'h0;  // Address of the previous own write
  logic wrote = 1'b0;  // A write to own space was done
  initial begin
    ale_o = 1'b0;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    cs_n_o = 1'b1;
    near_n_o = 1'b1;
    addr_o = 32'h0;
    be_n_o = 4'hF;
  end
  // One access; lat is -1 when nothing answers in 40 cycles
  task automatic access(input logic wr, cs, hint, input logic [31:0] a,
                        input logic [3:0] be, output int lat);
    lat = -1;
    @(posedge clk_i);
    ale_o <= 1'b1;
    rd_n_o <= wr;
    wr_n_o <= ~wr;
    cs_n_o <= ~cs;
    addr_o <= a;
    be_n_o <= be;
    // hint only when upper 22 bits match
    near_n_o <= ~(hint && wr && wrote && a[31:10] == last_wa[31:10]);
    for (int i = 0; i < 40 && lat < 0; i++) begin
      @(negedge clk_i);
      if (ack_n_i === 1'b0) lat = i;
    end
    @(posedge clk_i);
    ale_o <= 1'b0;
    rd_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    cs_n_o <= 1'b1;
    near_n_o <= 1'b1;
    addr_o <= ~a;  // Released bus shows no stale value
    be_n_o <= ~be;
    if (wr && cs) begin
      last_wa = a;
      wrote = 1'b1;
    end
    @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Bench: runs accesses through the processor model against a latency model.
// Assumes size code 0 until the last scenario, which checks a page under code 1.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import dram_seq_pkg::*;
  logic ref_clk_i, arst_n_i, row_to_column_delay_bit, slow, cp, hdis, ale, rd_n, wr_n, cs_n, nr_n;
  logic path, ack_n, po, s_path, page_v, last_wr;
  logic s_rb, s_oe, s_rboe, oe, rb_n, rb_oe;
  logic [11:0] dmux, s_dmux;
  logic [1:0] pulse, rp, dsz;
  logic [3:0] ras, cas, wbe, be_n, s_cas, s_wbe;
  logic [31:0] addr, open_tag, lw_a, a;
  logic [15:0] lf;
  logic [7:0] cfs [4] = '{8'h14, 8'h24, 8'h44, 8'h48};  // Settings that forbid bypass
  int bad_count = 0, n_compared = 0, cyc = 0, base, lat;
  dram_seq i_dram_seq (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .ale_i(ale),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .cs_n_i(cs_n), .near_write_hint_n_i(nr_n),
    .addr_i(addr), .byte_en_n_i(be_n), .dram_size_i(dsz),
    .row_to_column_delay_bit_i(row_to_column_delay_bit), .slow_select_bit_i(slow),
    .column_precharge_bit_i(cp), .cas_pulse_i(pulse), .near_hint_disable_bit_i(hdis),
    .ras_precharge_i(rp), .ras_n_o(ras), .cas_n_o(cas), .dram_mux_address_o(dmux),
    .bank_write_enables_n_o(wbe), .path_o(path), .ack_n_o(ack_n), .ack_oe_o(oe),
    .read_buffer_enable_n_o(rb_n), .read_buffer_enable_oe_o(rb_oe), .page_open_o(po));
  cpu_model i_cpu_model (.clk_i(ref_clk_i), .ack_n_i(ack_n), .ale_o(ale),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .cs_n_o(cs_n), .near_n_o(nr_n), .addr_o(addr),
    .be_n_o(be_n));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // Timeout guard
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      bad_count = bad_count + 1;
      give_verdict();
    end
  end
  // Capture strobes in the acknowledge cycle
  always @(negedge ref_clk_i) if (ack_n === 1'b0) begin
    s_cas = cas;
    s_wbe = wbe;
    s_path = path;
    s_rb = rb_n;
    s_oe = oe;
    s_rboe = rb_oe;
    s_dmux = dmux;
  end
  task automatic check(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Latency model from open page, last write and settings
  function automatic int exp_lat(input logic wr, cs, hint, input logic [31:0] a);
    int l;
    l = base + (pulse == 2'h1 ? 0 : 1);
    if (wr && hint && last_wr && a[31:10] == lw_a[31:10] && {slow, cp, hdis, pulse} == 5'h1)
      return base - 4;
    if (!cs) return -1;
    if (page_v && (a >> (12 + dsz)) == (open_tag >> (12 + dsz)))
      return l - 1 + int'(wr && slow);
    return l + row_to_column_delay_bit + (page_v ? 2 + rp : 0);
  endfunction
  // Next value of the stimulus shift register
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic cfg(input logic [7:0] c);
    @(posedge ref_clk_i);
    {row_to_column_delay_bit, slow, cp, hdis, pulse, rp} <= c;
  endtask
  task automatic go(input logic wr, cs, hint, input logic [31:0] a, input logic [3:0] be);
    logic [3:0] r;
    r = ras;
    i_cpu_model.access(wr, cs, hint, a, be, lat);
    check(lat, exp_lat(wr, cs, hint, a));
    if (cs) begin
      check(s_path, !a[2]);
      check(s_cas, be);
      check(s_wbe, wr ? (a[2] ? 4'h5 : 4'hA) : 4'hF);
      check(ras, a[21 + 2 * dsz] ? 4'h3 : 4'hC);
      check(s_rb, wr);
      check({s_oe, s_rboe}, 2'h3);
      check(s_dmux, (a >> 3) & ((32'h1 << (9 + dsz)) - 32'h1));
      page_v = 1'b1;
      open_tag = a;
    end else begin
      check(ras, r);
    end
    last_wr = wr && cs;
    if (last_wr) lw_a = a;
    $display("access at %0h done, latency %0d", a, lat);
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    arst_n_i = 1'b0;
    {row_to_column_delay_bit, slow, cp, hdis, pulse, rp} = 8'h04;
    dsz = 2'h0;
    {page_v, last_wr, lf} = 18'h0000E;
    repeat (6) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(negedge ref_clk_i);
    check({ras, cas, wbe, 3'h0, po}, 16'hFFF0);
    // Fresh read sets the reference latency
    i_cpu_model.access(1'b0, 1'b1, 1'b0, 32'h0, 4'h0, base);
    {page_v, open_tag} = 33'h100000000;
    check(ras, 4'hC);
    go(1'b0, 1'b1, 1'b0, 32'h4, 4'h0);
    go(1'b0, 1'b1, 1'b0, 32'h0020_0000, 4'h0);
    for (int i = 0; i < 4; i++) begin
      cfg(8'h04 | 8'(i));
      go(1'b0, 1'b1, 1'b0, 32'(i + 1) << 12, 4'h0);
    end
    cfg(8'h84);
    go(1'b0, 1'b1, 1'b0, 32'h0010_0000, 4'h0);
    cfg(8'h04);
    go(1'b1, 1'b1, 1'b0, 32'h0010_000C, 4'h3);
    go(1'b1, 1'b1, 1'b1, 32'h0010_0010, 4'h0);
    foreach (cfs[i]) begin
      cfg(cfs[i]);
      go(1'b1, 1'b1, 1'b1, 32'h0010_0018, 4'hC);
    end
    cfg(8'h04);
    go(1'b0, 1'b0, 1'b0, 32'h0010_0000, 4'h0);
    go(1'b1, 1'b1, 1'b1, 32'h0010_0018, 4'h0);
    for (int i = 0; i < 24; i++) begin
      lf = lfsr(lf);
      a = {10'h0, lf[0], 8'h0, lf[1], lf[11:2], 2'h0};
      go(lf[12], 1'b1, lf[5], a, lf[12] ? {1'b0, lf[15:13]} : 4'h0);
    end
    // Larger size code turns a page miss into a hit
    go(1'b0, 1'b1, 1'b0, 32'h0, 4'h0);
    @(posedge ref_clk_i);
    dsz <= 2'h1;
    go(1'b0, 1'b1, 1'b0, 32'h0000_1000, 4'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
